// >>> verilog/imd_cfg.svh
/*
 * register offsets, field positions, reset values and timing for the
 * integer multiply/divide unit.
 * assumes inclusion by bare name from the design files.
 */
`ifndef IMD_CFG_SVH
`define IMD_CFG_SVH

`define IMD_ADDR_W 16
`define IMD_OFS_SRC_LO 16'hff80
`define IMD_OFS_SRC_HI 16'hff81
`define IMD_OFS_DRL_LO 16'hff82
`define IMD_OFS_DRL_HI 16'hff83
`define IMD_OFS_DRH_LO 16'hff84
`define IMD_OFS_DRH_HI 16'hff85
`define IMD_OFS_CTRL 16'hff86

`define IMD_BIT_NEG 3
`define IMD_BIT_OVF 2
`define IMD_BIT_ZERO 1
`define IMD_BIT_MODE 0

`define IMD_FLAGS_RST 3'h0
`define IMD_BUSY_RST 1'h0
`define IMD_OP_CYCLES 4'ha

`endif

// >>> verilog/imd_pkg.sv
/*
 * types of the integer multiply/divide unit.
 * assumes nothing beyond a systemverilog compiler.
 */
`default_nettype none
package imd_pkg;
    typedef enum logic [0:0] {
        IMD_MUL = 1'b0,
        IMD_DIV = 1'b1
    } imd_mode_t;

    typedef enum logic [0:0] {
        IMD_IDLE = 1'b0,
        IMD_RUN = 1'b1
    } imd_state_t;

    typedef struct packed {
        logic neg;
        logic ovf;
        logic zero;
    } imd_flags_t;

    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        imd_flags_t flags;
        logic load;
    } imd_result_t;
endpackage : imd_pkg
`default_nettype wire

// >>> verilog/imd_arith.sv
/*
 * combinational unsigned 8x8 multiply and 16/8 divide with flags.
 * assumes operands are held stable by the caller while it samples.
 */
`default_nettype none
module imd_arith (
    input wire logic mode_in,            // 1 divide, 0 multiply
    input wire logic [7:0] src_in,       // multiplier or divisor
    input wire logic [15:0] dst_in,      // captured destination
    output logic [15:0] res_out,         // value to load
    output var imd_pkg::imd_flags_t flags_out, // resulting flags
    output logic load_out                // destination is rewritten
);
    logic [15:0] prod;
    logic [15:0] quot;
    logic [7:0] rem;
    logic ovf;

    always_comb begin
        prod = 16'(dst_in[7:0] * src_in);
        quot = 16'h0000;
        rem = 8'h00;
        ovf = 1'b1;
        if (src_in != 8'h00) begin
            quot = dst_in / {8'h00, src_in};
            rem = 8'(dst_in % {8'h00, src_in});
            ovf = (quot[15:8] != 8'h00);
        end
        if (mode_in == imd_pkg::IMD_DIV) begin
            res_out = ovf ? dst_in : {rem, quot[7:0]};
            flags_out.neg = quot[7];
            flags_out.zero = (quot[7:0] == 8'h00);
            flags_out.ovf = ovf;
            load_out = ~ovf;
        end else begin
            res_out = prod;
            flags_out.neg = prod[15];
            flags_out.zero = (prod == 16'h0000);
            flags_out.ovf = 1'b0;
            load_out = 1'b1;
        end
    end
endmodule : imd_arith
`default_nettype wire

// >>> verilog/imd_unit.sv
/*
 * integer multiply/divide unit on a 4-bit register port.
 * assumes one-cycle strobes, never both at once; read data one cycle later.
 */
//
// Contract
// - source byte as two nibbles, held
// - capture operands, finish in ten cycles
// - low product or quotient to low byte
// - divide overflow keeps the dividend
// - multiply ignores high byte, gets high product
// - divide uses high byte, gets remainder
// - negative flag bit 3, read only
// - overflow flag bit 2, cleared by multiply
// - zero flag bit 1, read only
// - writing bit 0 starts, value selects mode
// - bit 0 reads busy while running
// - results and flags update together
// - data registers are not reset
// - multiply flags from sixteen bit product
// - divide flags from quotient byte
// - overflow when quotient exceeds eight bits
`include "imd_cfg.svh"
`default_nettype none
module imd_unit (
    input wire logic sys_clk_in,                 // 40 MHz clock
    input wire logic resetn_in,                  // sync reset, active low
    input wire logic [`IMD_ADDR_W-1:0] addr_in,  // register address
    input wire logic [3:0] wdata_in,             // write data
    input wire logic wr_in,                      // write strobe
    input wire logic rd_in,                      // read strobe
    output logic [3:0] rdata_out,                // read data, next cycle
    output logic busy_out                        // operation running
);
    logic [7:0] src;
    logic [7:0] dest_low_byte;
    logic [7:0] dest_high_byte;
    logic [7:0] next_src;
    logic [7:0] next_drl;
    logic [7:0] next_drh;
    imd_pkg::imd_flags_t flags;
    imd_pkg::imd_flags_t next_flags;
    imd_pkg::imd_state_t state;
    imd_pkg::imd_state_t next_state;
    imd_pkg::imd_mode_t mode;
    imd_pkg::imd_mode_t next_mode;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [15:0] opnd;
    logic [15:0] next_opnd;
    logic [7:0] opsrc;
    logic [7:0] next_opsrc;
    logic [3:0] rdata;
    logic [3:0] next_rdata;
    imd_pkg::imd_result_t res;
    logic [15:0] ar_val;
    imd_pkg::imd_flags_t ar_flags;
    logic ar_load;

    function automatic logic hit(input logic [`IMD_ADDR_W-1:0] a,
                                 input logic [`IMD_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    imd_arith u_arith (
        .mode_in(mode),
        .src_in(opsrc),
        .dst_in(opnd),
        .res_out(ar_val),
        .flags_out(ar_flags),
        .load_out(ar_load)
    );

    always_comb begin
        res.hi = ar_val[15:8];
        res.lo = ar_val[7:0];
        res.flags = ar_flags;
        res.load = ar_load;
    end

    // operation sequencer
    always_comb begin
        next_state = state;
        next_mode = mode;
        next_cnt = cnt;
        next_opnd = opnd;
        next_opsrc = opsrc;
        next_flags = flags;
        if (state == imd_pkg::IMD_RUN) begin
            next_cnt = 4'(cnt - 4'h1);
        end
        unique case (state)
            imd_pkg::IMD_IDLE: begin
                if (wr_in && hit(addr_in, `IMD_OFS_CTRL)) begin
                    next_mode = imd_pkg::imd_mode_t'(wdata_in[`IMD_BIT_MODE]);
                    next_opsrc = src;
                    next_opnd = {(wdata_in[`IMD_BIT_MODE] ? dest_high_byte : 8'h00), dest_low_byte};
                    next_cnt = `IMD_OP_CYCLES;
                    next_state = imd_pkg::IMD_RUN;
                end
            end
            imd_pkg::IMD_RUN: begin
                if (cnt == 4'h1) begin
                    next_state = imd_pkg::IMD_IDLE;
                    next_flags = res.flags;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            state <= imd_pkg::IMD_IDLE;
            mode <= imd_pkg::IMD_MUL;
            cnt <= 4'h0;
            opnd <= 16'h0000;
            opsrc <= 8'h00;
            flags <= `IMD_FLAGS_RST;
        end else begin
            state <= next_state;
            mode <= next_mode;
            cnt <= next_cnt;
            opnd <= next_opnd;
            opsrc <= next_opsrc;
            flags <= next_flags;
        end
    end

    // data registers, deliberately left without reset
    always_comb begin
        next_src = src;
        next_drl = dest_low_byte;
        next_drh = dest_high_byte;
        if (wr_in) begin
            if (hit(addr_in, `IMD_OFS_SRC_LO)) next_src[3:0] = wdata_in;
            if (hit(addr_in, `IMD_OFS_SRC_HI)) next_src[7:4] = wdata_in;
            if (hit(addr_in, `IMD_OFS_DRL_LO)) next_drl[3:0] = wdata_in;
            if (hit(addr_in, `IMD_OFS_DRL_HI)) next_drl[7:4] = wdata_in;
            if (hit(addr_in, `IMD_OFS_DRH_LO)) next_drh[3:0] = wdata_in;
            if (hit(addr_in, `IMD_OFS_DRH_HI)) next_drh[7:4] = wdata_in;
        end
        // a loading completion overrides any destination write made against the busy rule; source writes stand
        if (state == imd_pkg::IMD_RUN && cnt == 4'h1 && res.load) begin
            next_drl = res.lo;
            next_drh = res.hi;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        src <= next_src;
        dest_low_byte <= next_drl;
        dest_high_byte <= next_drh;
    end

    // read port
    always_comb begin
        next_rdata = 4'h0;
        if (rd_in) begin
            if (hit(addr_in, `IMD_OFS_SRC_LO)) next_rdata = src[3:0];
            if (hit(addr_in, `IMD_OFS_SRC_HI)) next_rdata = src[7:4];
            if (hit(addr_in, `IMD_OFS_DRL_LO)) next_rdata = dest_low_byte[3:0];
            if (hit(addr_in, `IMD_OFS_DRL_HI)) next_rdata = dest_low_byte[7:4];
            if (hit(addr_in, `IMD_OFS_DRH_LO)) next_rdata = dest_high_byte[3:0];
            if (hit(addr_in, `IMD_OFS_DRH_HI)) next_rdata = dest_high_byte[7:4];
            if (hit(addr_in, `IMD_OFS_CTRL)) begin
                next_rdata[`IMD_BIT_NEG] = flags.neg;
                next_rdata[`IMD_BIT_OVF] = flags.ovf;
                next_rdata[`IMD_BIT_ZERO] = flags.zero;
                next_rdata[`IMD_BIT_MODE] = (state == imd_pkg::IMD_RUN);
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            rdata <= 4'h0;
        end else begin
            rdata <= next_rdata;
        end
    end

    always_comb begin
        rdata_out = rdata;
        busy_out = (state == imd_pkg::IMD_RUN);
    end
endmodule : imd_unit
`default_nettype wire

// >>> verif/imd_unit_props.sv
/* port checker for the multiply/divide unit.
   assumes a bind to imd_unit and the cfg header on the include path. */
`include "imd_cfg.svh"
`default_nettype none
module imd_unit_props (
    input wire logic sys_clk_in, // clock
    input wire logic resetn_in, // sync reset, low
    input wire logic [`IMD_ADDR_W-1:0] addr_in, // address
    input wire logic [3:0] wdata_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    input wire logic [3:0] rdata_out, // read data
    input wire logic busy_out // running
);
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);
    wire logic cw = wr_in && addr_in == `IMD_OFS_CTRL;
    wire logic cr = rd_in && addr_in == `IMD_OFS_CTRL;
    wire logic dw = wr_in && !busy_out && addr_in < `IMD_OFS_CTRL &&
        addr_in >= `IMD_OFS_SRC_LO;
    a_start_busy: assert property (cw && !busy_out |=> busy_out)
        else $error("busy did not follow a start");
    a_busy_ten: assert property ($rose(busy_out) |->
        busy_out[*8] ##1 busy_out ##1 busy_out ##1 !busy_out)
        else $error("busy not ten cycles long");
    a_busy_cause: assert property ($rose(busy_out) |-> $past(cw))
        else $error("busy rose without a start");
    a_status_bit: assert property (cr |=>
        rdata_out[0] == $past(busy_out)) else $error("status bit wrong");
    a_stay_idle: assert property (!busy_out && !cw |=> !busy_out)
        else $error("busy rose while idle");
    a_data_hold: assert property (dw ##1 !wr_in ##1 (rd_in &&
        !busy_out && addr_in == $past(addr_in, 2)) |=>
        rdata_out == $past(wdata_in, 3)) else $error("data not held");
    a_quiet_read: assert property (!rd_in |=> rdata_out == 4'h0)
        else $error("read data without a read");
    a_unmapped_zero: assert property (rd_in && addr_in > `IMD_OFS_CTRL |=>
        rdata_out == 4'h0) else $error("unmapped read not zero");
    c_mul: cover property (cw && !busy_out && !wdata_in[0]);
    c_div: cover property (cw && !busy_out && wdata_in[0]);
    c_busy_write: cover property (cw && busy_out);
endmodule : imd_unit_props
bind imd_unit imd_unit_props i_imd_unit_props (.sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .busy_out(busy_out));
`default_nettype wire

// >>> verif/imd_cpu_model.sv
/* cpu-side bus master for the multiply/divide unit.
   assumes one clock shared with the unit; the bench calls its tasks. */
`default_nettype none
module imd_cpu_model (
    input wire logic clk_in, // unit clock
    input wire logic [3:0] rdata_in, // read data
    output var logic [15:0] addr_out, // address
    output var logic [3:0] wdata_out, // write data
    output var logic wr_out, // write strobe
    output var logic rd_out // read strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr_out = 16'h0000;
        wdata_out = 4'h0;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    task automatic wr_reg(input logic [15:0] a, input logic [3:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        wdata_out <= ~d; // released data no longer shows the value
    endtask : wr_reg
    task automatic rd_reg(input logic [15:0] a, output logic [3:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        // read data stand for the cycle after the strobe only
        @(posedge clk_in);
        d = rdata_in;
    endtask : rd_reg
endmodule : imd_cpu_model
`default_nettype wire

// >>> verif/imd_unit_tb.sv
/* self-checking bench for the multiply/divide unit.
   assumes the cpu model, the checker bind and the cfg header. */
`include "imd_cfg.svh"
`default_nettype none
module imd_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] addr;
    logic [3:0] wdata;
    logic [3:0] rdata;
    logic wr;
    logic rd;
    logic busy;
    int num_errors = 0;
    int checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    imd_cpu_model i_imd_cpu_model (.clk_in(sys_clk), .rdata_in(rdata),
        .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
    imd_unit i_imd_unit (.sys_clk_in(sys_clk), .resetn_in(resetn),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .busy_out(busy));
    task automatic print_verdict;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // load operands, start, poke ctrl while busy, read result and flags
    task automatic run_op(input logic [7:0] s, input logic [15:0] d,
        input logic m, input logic [15:0] e, input logic [3:0] f, k);
        logic [23:0] v;
        logic [15:0] w;
        logic [3:0] r;
        v = {d, s};
        for (int i = 0; i < 6; i++) begin
            i_imd_cpu_model.wr_reg(`IMD_OFS_SRC_LO + 16'(i), v[4*i+:4]);
        end
        i_imd_cpu_model.rd_reg(`IMD_OFS_DRH_HI, r);
        chk({12'h0, r}, {12'h0, d[15:12]});
        i_imd_cpu_model.wr_reg(`IMD_OFS_CTRL, {3'h7, m});
        i_imd_cpu_model.rd_reg(`IMD_OFS_CTRL, r);
        chk({15'h0, r[0]}, 16'h0001);
        i_imd_cpu_model.wr_reg(`IMD_OFS_CTRL, {3'h0, ~m});
        repeat (7) @(posedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            i_imd_cpu_model.rd_reg(`IMD_OFS_DRL_LO + 16'(i), r);
            w[4*i+:4] = r;
        end
        chk(w, e);
        i_imd_cpu_model.rd_reg(`IMD_OFS_CTRL, r);
        chk({12'h0, r & k}, {12'h0, f});
        // source byte must survive the operation
        i_imd_cpu_model.rd_reg(`IMD_OFS_SRC_LO, r);
        chk({12'h0, r}, {12'h0, s[3:0]});
        i_imd_cpu_model.rd_reg(`IMD_OFS_SRC_HI, r);
        chk({12'h0, r}, {12'h0, s[7:4]});
    endtask : run_op
    initial begin
        #50000;
        num_errors++;
        print_verdict();
    end
    initial begin
        logic [3:0] r;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        i_imd_cpu_model.rd_reg(`IMD_OFS_CTRL, r);
        chk({12'h0, r}, 16'h0000);
        i_imd_cpu_model.rd_reg(16'hff87, r);
        chk({12'h0, r}, 16'h0000);
        run_op(8'h64, 16'h1a16, 1'b1, 16'h4e42, 4'h0, 4'hf);
        run_op(8'h64, 16'h332c, 1'b1, 16'h0083, 4'h8, 4'hf);
        run_op(8'h58, 16'h0000, 1'b1, 16'h0000, 4'h2, 4'hf);
        run_op(8'h13, 16'h2468, 1'b1, 16'h2468, 4'hc, 4'hf);
        run_op(8'h00, 16'h1234, 1'b1, 16'h1234, 4'h4, 4'h4);
        run_op(8'ha5, 16'hffc8, 1'b0, 16'h80e8, 4'h8, 4'hf);
        run_op(8'h64, 16'h7700, 1'b0, 16'h0000, 4'h2, 4'hf);
        run_op(8'h58, 16'h0064, 1'b0, 16'h2260, 4'h0, 4'hf);
        run_op(8'h58, 16'h00c8, 1'b0, 16'h44c0, 4'h0, 4'hf);
        print_verdict();
    end
endmodule : imd_unit_tb
`default_nettype wire
